// ===== hdl/sdes_drop_status.sv
// drop event capture, status register and APB slave
//
// Notes on behaviour
// - slot B reason in bits 14:11
// - 0000 tagged-only admission, untagged packet
// - 0001/0101 source non-member, unknown/known destination
// - 0010/0011/1001 port not forwarding cases
// - 0100 known destination port not member
// - 0110 unknown unicast, 0111 unknown multicast
// - 1000 broadcast over throttle limit
// - 1010 same port, 1011 filter flag
// - 1110 VLAN FFFh; reserved codes never produced
// - slot B source port in bits 10:9
// - bit 8 is slot B valid
// - slot A reason in bits 7:4
// - slot A source port in bits 3:2
// - bit 1 is slot A valid
// - bit 0 pending on any drop
// - mask bit, reset set, gates interrupt
// - two slots double buffer the status
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`include "sdes_defines.svh"
module sdes_drop_status (
  input wire logic sys_clk, // 200 MHz core clock
  input wire logic reset, // synchronous, active high
  input wire sdes_pkg::sdes_pkt_t pkt, // packet decision inputs
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  output logic dropIrq, // drop interrupt request, high active
  output logic dropStrobe // one pulse per recorded drop
);
  import sdes_pkg::*;

  // limitation: with both slots full, further drops are not kept;
  // only the pending bit records that they happened
  // capture slots; index 0 is slot A, index 1 is slot B
  sdes_slot_t slot_ff [2];
  sdes_slot_t nxt_slot [2];
  logic pending_ff;
  logic nxt_pending;
  logic mask_ff;
  logic nxt_mask;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pready_ff;
  logic nxt_pready;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic irq_ff;
  logic nxt_irq;
  logic strobe_ff;
  logic nxt_strobe;

  // drop causes, one wire each; several can be true for one packet
  // vlan id fff is refused before any other check
  wire vidNull = pkt.vlanId == `SDES_VID_NULL;
  // untagged or priority-only frame while tagged_only_admission is on
  wire tagOnlyHit = pkt.tagOnlyEn && pkt.untaggedOrPrio;
  // ingress membership refused for the source port
  wire srcRejected = pkt.memberCheckEn && !pkt.admitNonMember && !pkt.srcMember;
  // flooded frame from a port that is not forwarding
  wire floodSrcBlocked = !pkt.daFound && !pkt.srcFwd;
  // broadcast beyond the throttle budget
  wire bcastThrottled = !pkt.daFound && pkt.daBcast && pkt.bcastOverLimit;
  // unicast destination missing from the address_lookup_table
  wire unknownUcast = !pkt.daFound && !pkt.daBcast && !pkt.daMcast &&
    pkt.dropUnknownEn;
  // multicast destination missing while multicast filtering is on
  wire unknownMcast = !pkt.daFound && pkt.daMcast && pkt.filterMcastEn;
  // known destination entry carries the filter flag
  wire knownFiltered = pkt.daFound && pkt.daFilter;
  // known destination, source port not forwarding
  wire knownSrcBlocked = pkt.daFound && !pkt.srcFwd;
  // known destination, destination port not forwarding
  wire knownDstBlocked = pkt.daFound && !pkt.dstFwd;
  // known destination port outside the incoming vlan
  wire dstRejected = pkt.daFound && pkt.memberCheckEn && !pkt.dstMember;
  // known destination resolves back to the ingress port
  wire samePort = pkt.daFound && (pkt.srcPort == pkt.dstPort);

  // any cause at all means the packet is dropped
  wire dropHit = vidNull || tagOnlyHit || srcRejected || floodSrcBlocked ||
    bcastThrottled || unknownUcast || unknownMcast || knownFiltered ||
    knownSrcBlocked || knownDstBlocked || dstRejected || samePort;

  // one code per packet; priority follows the lookup pipeline order
  // reserved codes c, d and f have no path here
  sdes_code_t dropCode;
  assign dropCode = vidNull ? 4'he :
    tagOnlyHit ? 4'h0 :
    (srcRejected && pkt.daFound) ? 4'h5 :
    srcRejected ? 4'h1 :
    floodSrcBlocked ? 4'h9 :
    bcastThrottled ? 4'h8 :
    unknownUcast ? 4'h6 :
    unknownMcast ? 4'h7 :
    knownFiltered ? 4'hb :
    knownSrcBlocked ? 4'h2 :
    knownDstBlocked ? 4'h3 :
    dstRejected ? 4'h4 :
    4'ha;

  // a drop counts only in the cycle that carries the packet
  wire dropEvent = pkt.valid && dropHit;

  // register decode; only an access cycle without ready acts, so a held
  // access phase acts again every second cycle and can clear the status twice
  wire access = psel && penable;
  wire firstAccess = access && !pready_ff;
  wire hitMask = paddr == `SDES_ADDR_MASK;
  wire hitPend = paddr == `SDES_ADDR_PEND;
  wire unmapped = !hitMask && !hitPend;
  wire rdPend = firstAccess && !pwrite && hitPend;
  wire wrMask = firstAccess && pwrite && hitMask;

  // status word as software sees it; upper bits read as zero
  logic [31:0] pendWord;
  assign pendWord[31:15] = 17'h0;
  assign pendWord[`SDES_B_REASON_HI:`SDES_B_REASON_LO] = slot_ff[1].reason;
  assign pendWord[`SDES_B_PORT_HI:`SDES_B_PORT_LO] = slot_ff[1].port;
  assign pendWord[`SDES_B_VALID] = slot_ff[1].valid;
  assign pendWord[`SDES_A_REASON_HI:`SDES_A_REASON_LO] = slot_ff[0].reason;
  assign pendWord[`SDES_A_PORT_HI:`SDES_A_PORT_LO] = slot_ff[0].port;
  assign pendWord[`SDES_A_VALID] = slot_ff[0].valid;
  assign pendWord[`SDES_PENDING] = pending_ff;
  wire [31:0] maskWord = {31'h0, mask_ff};
  wire [31:0] rdData = hitPend ? pendWord : (hitMask ? maskWord : 32'h0);

  // fresh capture for whichever slot takes the event
  sdes_slot_t fresh;
  assign fresh = '{valid: 1'h1, reason: dropCode, port: pkt.srcPort};

  // a slot being read out counts as free, so an event in the read
  // cycle survives the clear and lands in slot A
  logic [1:0] slotFree;
  logic [1:0] lowerFull;
  logic [1:0] slotTake;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_slot
      assign slotFree[gi] = rdPend || !slot_ff[gi].valid;
      if (gi == 0)
      begin : g_first
        assign lowerFull[gi] = 1'h1;
      end
      else
      begin : g_next
        assign lowerFull[gi] = lowerFull[gi - 1] && !slotFree[gi - 1];
      end
      // first free slot wins; with both full the event is not kept
      assign slotTake[gi] = dropEvent && slotFree[gi] && lowerFull[gi];
      assign nxt_slot[gi] = slotTake[gi] ? fresh : (rdPend ? '0 : slot_ff[gi]);

      always_ff @(posedge sys_clk)
      begin
        if (reset)
        begin
          slot_ff[gi] <= '0;
        end
        else
        begin
          slot_ff[gi] <= nxt_slot[gi];
        end
      end
    end
  endgenerate

  // the set wins over a read in the same cycle
  assign nxt_pending = dropEvent || (pending_ff && !rdPend);
  assign nxt_mask = wrMask ? pwdata[0] : mask_ff;
  // one wait state: ready follows the first access cycle by one edge
  assign nxt_pready = firstAccess;
  assign nxt_pslverr = firstAccess && unmapped;
  // snapshot before the clear; zero outside the ready cycle
  assign nxt_prdata = (firstAccess && !pwrite) ? rdData : 32'h0;
  // mask from the previous cycle; the status is never touched by it
  assign nxt_irq = nxt_pending && !mask_ff;
  assign nxt_strobe = dropEvent;

  // pending flag
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      pending_ff <= 1'h0;
    end
    else
    begin
      pending_ff <= nxt_pending;
    end
  end

  // interrupt mask, set out of reset so nothing fires before setup
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      mask_ff <= `SDES_MASK_RST;
    end
    else
    begin
      mask_ff <= nxt_mask;
    end
  end

  // read data register
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      prdata_ff <= 32'h0;
    end
    else
    begin
      prdata_ff <= nxt_prdata;
    end
  end

  // ready pulse; it also blocks an action in the cycle right after one in a held access
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      pready_ff <= 1'h0;
    end
    else
    begin
      pready_ff <= nxt_pready;
    end
  end

  // error pulse for unmapped addresses
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      pslverr_ff <= 1'h0;
    end
    else
    begin
      pslverr_ff <= nxt_pslverr;
    end
  end

  // interrupt request level
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      irq_ff <= 1'h0;
    end
    else
    begin
      irq_ff <= nxt_irq;
    end
  end

  // one pulse per recorded drop, even when no slot keeps it
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      strobe_ff <= 1'h0;
    end
    else
    begin
      strobe_ff <= nxt_strobe;
    end
  end

  // every output comes straight from a flop
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign dropIrq = irq_ff;
  assign dropStrobe = strobe_ff;
endmodule // sdes_drop_status

// ===== shared/sdes_defines.svh
// constant macros for the drop event status block
`ifndef SDES_DEFINES_SVH
`define SDES_DEFINES_SVH
`define SDES_ADDR_MASK 12'h000
`define SDES_ADDR_PEND 12'h004
`define SDES_MASK_RST 1'h1
`define SDES_B_REASON_HI 14
`define SDES_B_REASON_LO 11
`define SDES_B_PORT_HI 10
`define SDES_B_PORT_LO 9
`define SDES_B_VALID 8
`define SDES_A_REASON_HI 7
`define SDES_A_REASON_LO 4
`define SDES_A_PORT_HI 3
`define SDES_A_PORT_LO 2
`define SDES_A_VALID 1
`define SDES_PENDING 0
`define SDES_VID_NULL 12'hfff
`endif

// ===== shared/sdes_pkg.sv
// types for the drop event status block
package sdes_pkg;
  typedef logic [3:0] sdes_code_t;
  typedef logic [1:0] sdes_port_t;
  // one packet's drop-decision inputs, presented for a single cycle
  typedef struct packed {
    logic valid;
    sdes_port_t srcPort;
    sdes_port_t dstPort;
    logic daFound;
    logic daBcast;
    logic daMcast;
    logic daFilter;
    logic untaggedOrPrio;
    logic tagOnlyEn;
    logic memberCheckEn;
    logic admitNonMember;
    logic srcMember;
    logic dstMember;
    logic srcFwd;
    logic dstFwd;
    logic dropUnknownEn;
    logic filterMcastEn;
    logic bcastOverLimit;
    logic [11:0] vlanId;
  } sdes_pkt_t;
  typedef struct packed {
    logic valid;
    sdes_code_t reason;
    sdes_port_t port;
  } sdes_slot_t;
endpackage

// ===== test/sdes_drop_status_monitor.sv
// assertion checker for the drop event status block
`timescale 1ns/10ps
module sdes_drop_status_monitor (
  input wire logic sys_clk, // core clock
  input wire logic reset, // sync reset
  input wire sdes_pkg::sdes_pkt_t pkt, // packet inputs
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic dropStrobe // drop pulse
);
  import sdes_pkg::*;
  wire logic rdPend;
  assign rdPend = pready && !pwrite && paddr == 12'h004;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  wait_state_a: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held");
  slverr_map_a: assert property (pready |-> pslverr == (paddr != 12'h000 && paddr != 12'h004))
    else $error("error flag wrong");
  code_resv_a: assert property (rdPend |-> !(prdata[7:4] inside {4'hc, 4'hd, 4'hf}))
    else $error("reserved code");
  slot_order_a: assert property (rdPend && prdata[8] |-> prdata[1] && prdata[0])
    else $error("slot b before a");
  port_code_a: assert property (rdPend && prdata[1] |-> prdata[3:2] != 2'h3)
    else $error("reserved port");
  drop_strobe_a: assert property (dropStrobe |-> $past(pkt.valid))
    else $error("strobe without packet");
  mask_read_a: assert property (pready && paddr == 12'h000 |-> prdata[31:1] == 31'h0)
    else $error("mask upper bits");
endmodule // sdes_drop_status_monitor
bind sdes_drop_status sdes_drop_status_monitor sdes_drop_status_monitor_i (.sys_clk, .reset,
  .pkt, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .dropStrobe);

// ===== test/sdes_drop_status_tb_top.sv
// self-checking bench for the drop event status block
`timescale 1ns/10ps
module sdes_drop_status_tb_top;
  import sdes_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  sdes_pkt_t pkt = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, dropIrq, dropStrobe, err;
  int miscompares = 0;
  int n_checks = 0;
  sdes_code_t cs [13] = '{4'h0, 4'h1, 4'h5, 4'h9, 4'h8, 4'h6, 4'h7, 4'hb, 4'h2, 4'h3, 4'h4,
    4'ha, 4'he};
  always #2.5 sys_clk = ~sys_clk;
  sdes_drop_status sdes_drop_status_i (.sys_clk, .reset, .pkt, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .dropIrq, .dropStrobe);
  // each code gets exactly one cause true, so priority cannot hide it
  function automatic sdes_pkt_t mk(sdes_code_t c);
    mk = '{valid:1'b1, srcPort:2'(c % 3), dstPort:(c == 4'ha) ? 2'(c % 3) : 2'((c % 3 + 1) % 3),
      daFound:!(c inside {4'h1, 4'h9, 4'h8, 4'h6, 4'h7}), daBcast:c == 4'h8, daMcast:c == 4'h7,
      daFilter:c == 4'hb, untaggedOrPrio:c == 4'h0, tagOnlyEn:c == 4'h0, admitNonMember:1'b0,
      memberCheckEn:c inside {4'h1, 4'h5, 4'h4}, srcMember:!(c inside {4'h1, 4'h5}),
      dstMember:c != 4'h4, srcFwd:!(c inside {4'h9, 4'h2}), dstFwd:c != 4'h3,
      dropUnknownEn:c == 4'h6, filterMcastEn:c == 4'h7, bcastOverLimit:c == 4'h8,
      vlanId:(c == 4'he) ? 12'hfff : 12'h001};
  endfunction
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  // one idle edge after each transfer keeps psel from being driven twice in a step
  task apb(input logic w, input logic [11:0] a);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge sys_clk);
    miscompares += (n == 20);
    if (n == 20) close_out();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task send(input sdes_code_t c);
    pkt <= mk(c);
    @(posedge sys_clk);
    pkt.valid <= 1'b0;
    @(posedge sys_clk);
  endtask
  initial
  begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    apb(1'b0, 12'h000);
    chk(rd, 32'h1);
    apb(1'b0, 12'h004);
    chk(rd, 32'h0);
    foreach (cs[i])
    begin
      send(cs[i]);
      chk({31'h0, dropStrobe}, 32'h1);
      chk({31'h0, dropIrq}, 32'h0);
      apb(1'b0, 12'h004);
      chk(rd, {24'h0, cs[i], 2'(cs[i] % 3), 2'h3});
    end
    apb(1'b0, 12'h004);
    chk(rd, 32'h0);
    apb(1'b1, 12'h000);
    send(4'h6);
    chk({31'h0, dropIrq}, 32'h1);
    send(4'h8);
    send(4'he);
    apb(1'b0, 12'h004);
    chk(rd, {17'h0, 4'h8, 2'h2, 1'b1, 4'h6, 2'h0, 2'h3});
    chk({31'h0, dropIrq}, 32'h0);
    apb(1'b0, 12'h008);
    chk({rd[31:1], err}, 32'h1);
    close_out();
  end
endmodule // sdes_drop_status_tb_top
